// File: src/dss_pkg.sv
// constants and types shared by the drive step sequencer
package dss_pkg;

  // step table geometry
  localparam int STEP_NUM = 15;
  localparam int DUR_W    = 16;
  localparam int FREQ_W   = 16;
  localparam int PROF_W   = 3;
  localparam int IDX_W    = 4;

  // sequence mode codes
  localparam logic [1:0] MODE_STOP_AFTER = 2'h0;
  localparam logic [1:0] MODE_HOLD_LAST  = 2'h1;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [1:0] MODE_RESET_VAL  = MODE_CONTINUOUS;

  // resume policy codes
  localparam logic [1:0] RESUME_FIRST    = 2'h0;
  localparam logic [1:0] RESUME_STEP     = 2'h1;
  localparam logic [1:0] RESUME_FREQ     = 2'h2;
  localparam logic [1:0] RESUME_RESET_VAL = RESUME_FIRST;

  // outage retention and duration unit codes
  localparam logic RETAIN_DISCARD = 1'b0;
  localparam logic RETAIN_KEEP    = 1'b1;
  localparam logic UNIT_SECOND    = 1'b0;
  localparam logic UNIT_MINUTE    = 1'b1;

  // durations in tenths of the selected unit
  localparam logic [DUR_W-1:0] DUR_DEFAULT   = 16'h0064;
  localparam logic [DUR_W-1:0] DUR_MAX       = 16'h8CA0;
  localparam logic [DUR_W-1:0] DUR_FIRST_MIN = 16'h0001;
  localparam logic [DUR_W-1:0] DUR_ZERO      = 16'h0000;

  // profile code: bits 2:1 ramp set minus one, bit 0 direction
  localparam int PROF_DIR_BIT = 0;
  localparam int PROF_SET_LSB = 1;
  localparam logic [PROF_W-1:0] PROF_RAMP1_FORWARD = 3'h0;
  localparam logic [PROF_W-1:0] PROF_RAMP4_REVERSE = 3'h7;
  localparam logic DIR_FORWARD = 1'b0;
  localparam logic DIR_REVERSE = 1'b1;

  // step index values
  localparam logic [IDX_W-1:0] IDX_NONE  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_FIRST = 4'h1;

  // timebase
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TENTH_SEC_NS     = 100_000_000;
  localparam int TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN      = 60;
  localparam logic [5:0] PRESCALE_LAST = 6'(SEC_PER_MIN - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} dss_state_e;

endpackage : dss_pkg

// File: src/dss_tick_gen.sv
// tenth-of-second enable pulse divider with hold and restart
`timescale 1ns/1ps
module dss_tick_gen #(
  parameter int CYCLES = 10
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic enable,
  input  wire logic restart,
  // pulse out
  output logic      tick
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;

  // count holds while disabled so a pause keeps the partial interval
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (enable) begin
      tick <= (cnt == CNT_LAST);
      cnt  <= (cnt == CNT_LAST) ? '0 : cnt + CW'(1);
    end else begin
      tick <= 1'b0;
    end
  end

endmodule : dss_tick_gen

// File: src/dss_sequencer.sv
// drive step sequencer: timed steps, cycle modes, resume and retention
`timescale 1ns/1ps
// Notes on behaviour
// - mode 0 stop, 1 hold, 2 continuous
// - mode 0: stop after cycle, await run
// - mode 1: hold last step frequency, direction
// - mode 2: wrap until stop, fault, outage
// - policy 0: interruption restarts at first step
// - policy 1: resume step for remaining time
// - policy 2: also restart at stored frequency
// - retention 0: discard state on power loss
// - retention 1: keep state, resume per policy
// - unit seconds or minutes; ramps stay seconds
// - fifteen durations, 0 to 3600, first 0.1
// - zero duration step is skipped
// - profile picks ramp set and direction
// - index status shows current step
// - elapsed status shows current step time
// - clear zeroes index, elapsed; self-returns
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int TENTH_CYCLES = TENTH_SEC_CYCLES
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  // configuration
  input  wire logic [1:0]                        sequence_mode_select,
  input  wire logic [1:0]                        resume_policy,
  input  wire logic                              outage_retention,
  input  wire logic                              duration_unit,
  input  wire logic [STEP_NUM-1:0][DUR_W-1:0]    step_duration,
  input  wire logic [STEP_NUM-1:0][PROF_W-1:0]   step_profile,
  input  wire logic [STEP_NUM-1:0][FREQ_W-1:0]   step_freq,
  input  wire logic                              history_clear,
  // terminal and supervisor pins
  input  wire logic                              run_cmd,
  input  wire logic                              stop_cmd,
  input  wire logic                              pause_req,
  input  wire logic                              seq_reset_req,
  input  wire logic                              fault,
  input  wire logic                              power_fail,
  // from ramp generator
  input  wire logic [FREQ_W-1:0]                 running_freq,
  // to ramp generator
  output logic                                   run_enable,
  output logic [FREQ_W-1:0]                      target_freq,
  output logic [1:0]                             ramp_set,
  output logic                                   direction,
  output logic                                   stop_pulse,
  // status
  output logic [IDX_W-1:0]                       active_step_index,
  output logic [DUR_W-1:0]                       active_step_elapsed,
  output logic                                   history_clear_busy,
  output logic                                   cycle_done
);

  // two-stage synchronisers for pins, third stage for edges
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= {power_fail, fault, seq_reset_req, pause_req,
                   stop_cmd, run_cmd};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic run_rise;
  logic stop_rise;
  logic paused;
  logic reset_rise;
  logic fault_lvl;
  logic power_lvl;
  logic power_rise;

  assign run_rise   = pin_sync[0] & ~pin_prev[0];
  assign stop_rise  = pin_sync[1] & ~pin_prev[1];
  assign paused     = pin_sync[2];
  assign reset_rise = pin_sync[3] & ~pin_prev[3];
  assign fault_lvl  = pin_sync[4];
  assign power_lvl  = pin_sync[5];
  assign power_rise = pin_sync[5] & ~pin_prev[5];

  // clamped duration of a step, index 1..15; first step never zero
  function automatic logic [DUR_W-1:0] dur_of(input logic [IDX_W-1:0] i);
    logic [DUR_W-1:0] d;
    d = DUR_ZERO;
    if (i != IDX_NONE) begin
      d = step_duration[i - IDX_FIRST];
    end
    if (d > DUR_MAX) begin
      d = DUR_MAX;
    end
    if (i == IDX_FIRST && d < DUR_FIRST_MIN) begin
      d = DUR_FIRST_MIN;
    end
    return d;
  endfunction : dur_of

  // first step at or after from with nonzero duration, zero if none
  function automatic logic [IDX_W-1:0] next_step(input logic [4:0] from);
    logic [IDX_W-1:0] r;
    r = IDX_NONE;
    for (int k = STEP_NUM; k >= 1; k--) begin
      if (5'(k) >= from && dur_of(IDX_W'(k)) != DUR_ZERO) begin
        r = IDX_W'(k);
      end
    end
    return r;
  endfunction : next_step

  dss_state_e       state;
  logic [IDX_W-1:0] idx;
  logic [DUR_W-1:0] elapsed;
  logic             freq_override;
  logic [5:0]       prescale;
  logic             step_load;
  logic             tenth_tick;
  logic             clear_seen;

  logic             ctx_valid;
  logic [IDX_W-1:0] ctx_idx;
  logic [DUR_W-1:0] ctx_elapsed;
  logic [FREQ_W-1:0] ctx_freq;

  // event priority: outage, halt, reset, clear, run, timing
  logic ev_power;
  logic ev_halt;
  logic ev_reset;
  logic ev_clear;
  logic ev_run;
  logic counting;
  logic unit_tick;
  logic step_end;
  logic cycle_end;
  logic [IDX_W-1:0] first_idx;
  logic [IDX_W-1:0] follow_idx;
  logic resume_ctx;

  assign ev_power = power_rise;
  assign ev_halt  = ~ev_power & (state != ST_IDLE)
                  & (fault_lvl | stop_rise);
  assign ev_reset = ~ev_power & ~ev_halt & reset_rise;
  assign ev_clear = ~ev_power & ~ev_halt & ~ev_reset & history_clear;
  assign ev_run   = ~ev_power & ~ev_halt & ~ev_reset & ~ev_clear
                  & run_rise & (state == ST_IDLE) & ~power_lvl
                  & ~fault_lvl;

  assign counting = (state == ST_RUN) & ~paused & (idx != IDX_NONE);
  assign unit_tick = tenth_tick & counting
                   & (duration_unit == UNIT_SECOND
                      | prescale == PRESCALE_LAST);

  assign first_idx  = next_step(5'(IDX_FIRST));
  assign follow_idx = next_step({1'b0, idx} + 5'h01);
  assign step_end   = unit_tick
                    & ({1'b0, elapsed} + 17'h0_0001 >= {1'b0, dur_of(idx)});
  assign cycle_end  = step_end & (follow_idx == IDX_NONE);
  assign resume_ctx = ctx_valid & (resume_policy != RESUME_FIRST);

  dss_tick_gen #(
    .CYCLES (TENTH_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (counting),
    .restart (step_load),
    .tick    (tenth_tick)
  );

  // tenth-of-minute prescaler in minute mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale <= '0;
    end else if (step_load) begin
      prescale <= '0;
    end else if (tenth_tick & counting) begin
      prescale <= (prescale == PRESCALE_LAST) ? '0 : prescale + 6'h01;
    end
  end

  // sequencing: state, step index and elapsed time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state         <= ST_IDLE;
      idx           <= IDX_NONE;
      elapsed       <= '0;
      freq_override <= 1'b0;
      step_load     <= 1'b0;
      stop_pulse    <= 1'b0;
    end else begin
      step_load  <= 1'b0;
      stop_pulse <= 1'b0;
      if (ev_power) begin
        state <= ST_IDLE;
        if (outage_retention == RETAIN_DISCARD) begin
          idx     <= IDX_NONE;
          elapsed <= '0;
        end
      end else if (ev_halt) begin
        state <= ST_IDLE;
      end else if (ev_reset | ev_clear) begin
        idx           <= IDX_NONE;
        elapsed       <= '0;
        freq_override <= 1'b0;
        if (ev_reset & state == ST_HOLD) begin
          state <= ST_RUN;
        end
      end else if (ev_run) begin
        state     <= ST_RUN;
        step_load <= 1'b1;
        if (resume_ctx) begin
          idx           <= ctx_idx;
          elapsed       <= ctx_elapsed;
          freq_override <= (resume_policy == RESUME_FREQ);
        end else begin
          idx           <= first_idx;
          elapsed       <= '0;
          freq_override <= 1'b0;
        end
      end else if (state == ST_RUN) begin
        if (idx == IDX_NONE) begin
          idx       <= first_idx;
          elapsed   <= '0;
          step_load <= 1'b1;
        end else if (step_end) begin
          freq_override <= 1'b0;
          step_load     <= 1'b1;
          elapsed       <= '0;
          if (!cycle_end) begin
            idx <= follow_idx;
          end else begin
            case (sequence_mode_select)
              MODE_STOP_AFTER: begin
                state      <= ST_IDLE;
                stop_pulse <= 1'b1;
                elapsed    <= elapsed;
              end
              MODE_HOLD_LAST: begin
                state   <= ST_HOLD;
                elapsed <= elapsed;
              end
              default: begin
                idx <= first_idx;
              end
            endcase
          end
        end else if (unit_tick) begin
          elapsed <= elapsed + 16'h0001;
        end
      end
    end
  end

  // saved context for resume after stop, fault or outage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctx_valid   <= 1'b0;
      ctx_idx     <= IDX_NONE;
      ctx_elapsed <= '0;
      ctx_freq    <= '0;
    end else if (ev_power) begin
      if (outage_retention == RETAIN_KEEP) begin
        if (state == ST_RUN && idx != IDX_NONE) begin
          ctx_valid   <= 1'b1;
          ctx_idx     <= idx;
          ctx_elapsed <= elapsed;
          ctx_freq    <= running_freq;
        end
      end else begin
        ctx_valid <= 1'b0;
      end
    end else if (ev_halt) begin
      ctx_valid   <= (state == ST_RUN) & (idx != IDX_NONE);
      ctx_idx     <= idx;
      ctx_elapsed <= elapsed;
      ctx_freq    <= running_freq;
    end else if (ev_reset | ev_clear | ev_run | cycle_end) begin
      ctx_valid <= 1'b0;
    end
  end

  // drive commands to the ramp generator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_enable  <= 1'b0;
      target_freq <= '0;
      ramp_set    <= '0;
      direction   <= DIR_FORWARD;
    end else begin
      run_enable <= (state != ST_IDLE);
      if (idx != IDX_NONE) begin
        target_freq <= freq_override ? ctx_freq
                                     : step_freq[idx - IDX_FIRST];
        ramp_set    <= step_profile[idx - IDX_FIRST][PROF_SET_LSB +: 2];
        direction   <= step_profile[idx - IDX_FIRST][PROF_DIR_BIT];
      end
    end
  end

  // status outputs and self-returning clear flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_step_index   <= IDX_NONE;
      active_step_elapsed <= '0;
      history_clear_busy  <= 1'b0;
      clear_seen          <= 1'b0;
      cycle_done          <= 1'b0;
    end else begin
      active_step_index   <= idx;
      active_step_elapsed <= elapsed;
      // busy lines up with the zeroed status, one edge after idx clears
      clear_seen          <= ev_clear;
      history_clear_busy  <= clear_seen;
      if (cycle_end & sequence_mode_select != MODE_CONTINUOUS) begin
        cycle_done <= 1'b1;
      end else if (ev_run | ev_reset | ev_clear) begin
        cycle_done <= 1'b0;
      end
    end
  end

endmodule : dss_sequencer

// File: tb/dss_sequencer_assertions.sv
// port-level assertions for the drive step sequencer
`timescale 1ns/1ps
module dss_seq_checker
  import dss_pkg::*;
#(
  parameter int TENTH_CYCLES = 4
) (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // inputs
  input wire logic [1:0]       sequence_mode_select,
  input wire logic             history_clear,
  input wire logic             pause_req,
  // outputs
  input wire logic             run_enable,
  input wire logic             stop_pulse,
  input wire logic [IDX_W-1:0] active_step_index,
  input wire logic [DUR_W-1:0] active_step_elapsed,
  input wire logic             history_clear_busy,
  input wire logic             cycle_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // cycles since the elapsed status last moved
  logic [DUR_W-1:0] prev_el;
  logic [15:0]      gap;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_el <= '0;
      gap     <= '0;
    end else begin
      prev_el <= active_step_elapsed;
      gap     <= (active_step_elapsed != prev_el) ? 16'h0 : gap + 16'h1;
    end
  end

  stop_once_a: assert property (stop_pulse |=> !stop_pulse)
    else $error("stop pulse longer than one cycle");
  stop_mode_a: assert property (stop_pulse |->
    sequence_mode_select == MODE_STOP_AFTER ##[0:1] cycle_done && !run_enable)
    else $error("stop pulse without a halted single cycle");
  hold_run_a: assert property ($rose(cycle_done) &&
    sequence_mode_select == MODE_HOLD_LAST |-> run_enable[*2])
    else $error("hold mode dropped the drive at cycle end");
  no_end_a: assert property (
    sequence_mode_select[1] |-> !$rose(cycle_done))
    else $error("continuous mode ended its cycle");
  run_idx_a: assert property (
    $rose(run_enable) |-> active_step_index != IDX_NONE)
    else $error("drive started without a step index");
  busy_zero_a: assert property (history_clear_busy |->
    active_step_index == IDX_NONE && active_step_elapsed == DUR_ZERO
    ##1 !history_clear_busy)
    else $error("clear acknowledge wrong");
  el_max_a: assert property (active_step_elapsed <= DUR_MAX)
    else $error("elapsed time beyond range");
  el_step_a: assert property ($changed(active_step_elapsed) |->
    active_step_elapsed == $past(active_step_elapsed) + 16'h1 ||
    active_step_elapsed == DUR_ZERO)
    else $error("elapsed time jumped");
  tick_gap_a: assert property (
    active_step_elapsed == prev_el + 16'h1 |-> gap >= 16'(TENTH_CYCLES - 1))
    else $error("elapsed time advanced too fast");
  pause_frz_a: assert property (
    (pause_req && !history_clear)[*6] |=> $stable(active_step_elapsed))
    else $error("elapsed time moved while paused");
endmodule : dss_seq_checker

bind dss_sequencer dss_seq_checker #(.TENTH_CYCLES(TENTH_CYCLES)) i_chk (
  .sys_clk, .rst, .sequence_mode_select, .history_clear, .pause_req,
  .run_enable, .stop_pulse, .active_step_index, .active_step_elapsed,
  .history_clear_busy, .cycle_done);

// File: tb/dss_ramp_model.sv
// behavioural ramp generator facing the sequencer
`timescale 1ns/1ps
module dss_ramp_model
  import dss_pkg::*;
#(
  parameter int RATE = 1
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // command from the sequencer
  input  wire logic              run_enable,
  input  wire logic [FREQ_W-1:0] target_freq,
  // bench stall
  input  wire logic              hold_ramp,
  // ramp output
  output logic [FREQ_W-1:0]      running_freq
);
  logic [FREQ_W-1:0] goal;
  assign goal = run_enable ? target_freq : '0;

  // slow ramp so a stored frequency differs from the step target
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      running_freq <= '0;
    else if (!hold_ramp && running_freq < goal)
      running_freq <= running_freq + FREQ_W'(RATE);
    else if (!hold_ramp && running_freq > goal)
      running_freq <= running_freq - FREQ_W'(RATE);
  end
endmodule : dss_ramp_model

// File: tb/dss_sequencer_test.sv
// self-checking bench for the drive step sequencer
`timescale 1ns/1ps
module dss_sequencer_test
  import dss_pkg::*;
;
  localparam int TC = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode, pol, rset;
  logic ret, unit, hclr, pause, fault, hold, run_en, dir, cdone;
  logic spls, busy;
  logic [3:0] cmd; // run, stop, reset, power
  logic [STEP_NUM-1:0][DUR_W-1:0]  dur;
  logic [STEP_NUM-1:0][PROF_W-1:0] prof;
  logic [STEP_NUM-1:0][FREQ_W-1:0] frq;
  logic [FREQ_W-1:0] rfreq, tfreq, f;
  logic [IDX_W-1:0] idx, last;
  logic [DUR_W-1:0] el, e;
  logic [IDX_W-1:0] exp_q[$];
  int miscompares = 0, checked = 0, cycles = 0, n;

  dss_sequencer #(.TENTH_CYCLES(TC)) i_dss_sequencer (
    .sys_clk(sys_clk), .rst(rst), .sequence_mode_select(mode),
    .resume_policy(pol), .outage_retention(ret), .duration_unit(unit),
    .step_duration(dur), .step_profile(prof), .step_freq(frq),
    .history_clear(hclr), .run_cmd(cmd[0]), .stop_cmd(cmd[1]),
    .pause_req(pause), .seq_reset_req(cmd[2]), .fault(fault),
    .power_fail(cmd[3]), .running_freq(rfreq), .run_enable(run_en),
    .target_freq(tfreq), .ramp_set(rset), .direction(dir),
    .stop_pulse(spls), .active_step_index(idx), .active_step_elapsed(el),
    .history_clear_busy(busy), .cycle_done(cdone));

  dss_ramp_model i_dss_ramp_model (
    .sys_clk(sys_clk), .rst(rst), .run_enable(run_en),
    .target_freq(tfreq), .hold_ramp(hold), .running_freq(rfreq));

  always #5 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp

  // every change of the step status is checked against the oldest note
  always @(posedge sys_clk) begin
    if (!rst && idx !== last) begin
      if (exp_q.size() == 0)
        cmp("unexpected step", 16'(last), 16'(idx));
      else
        cmp("step index", 16'(exp_q.pop_front()), 16'(idx));
    end
    last <= idx;
  end

  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic pulse(int b);
    cmd[b] = 1'b1;
    cyc(4);
    cmd[b] = 1'b0;
    cyc(4);
  endtask : pulse

  task automatic drain;
    while (exp_q.size() != 0) cyc(1);
  endtask : drain

  task automatic run13;
    exp_q.push_back(4'h1);
    exp_q.push_back(4'h3);
    pulse(0);
    drain;
  endtask : run13

  task automatic clear;
    exp_q.push_back(4'h0);
    hclr = 1'b1;
    cyc(1);
    hclr = 1'b0;
    cyc(1);
    cmp("clear busy", 16'h1, 16'(busy));
    cyc(1);
    cmp("busy returns", 16'h0, 16'(busy));
    cyc(2);
    cmp("cleared time", 16'h0, el);
    drain;
  endtask : clear

  task automatic wait_done(output int k);
    k = 0;
    while (cdone !== 1'b1) begin
      cyc(1);
      k++;
    end
  endtask : wait_done

  initial begin
    void'($urandom(79386));
    {mode, pol, ret, unit, hclr, pause, fault, hold, cmd} = '0;
    mode = MODE_CONTINUOUS;
    dur = '0;
    dur[0] = 16'h0002;
    dur[2] = 16'h0006;
    for (int i = 0; i < STEP_NUM; i++) begin
      prof[i] = PROF_W'($urandom);
      frq[i] = FREQ_W'($urandom) | 16'h8000;
    end
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    cyc(2);
    // wrap with a skipped step, pause, stop, fault
    exp_q.push_back(4'h1);
    exp_q.push_back(4'h3);
    run13;
    pause = 1'b1;
    cyc(8);
    e = el;
    cyc(20);
    cmp("paused time", e, el);
    pause = 1'b0;
    cmp("ramp set", 16'(prof[2][2:1]), 16'(rset));
    cmp("direction", 16'(prof[2][0]), 16'(dir));
    cmp("target", frq[2], tfreq);
    pulse(1);
    cmp("run after stop", 16'h0, 16'(run_en));
    exp_q.push_back(4'h1);
    pulse(0);
    drain;
    fault = 1'b1;
    cyc(6);
    cmp("run after fault", 16'h0, 16'(run_en));
    fault = 1'b0;
    cyc(4);
    clear;
    // single-cycle stop and hold
    for (int m = 0; m < 2; m++) begin
      mode = 2'(m);
      run13;
      wait_done(n);
      cmp("stop pulse", 16'(m == 0), 16'(spls));
      cyc(2);
      cmp("run at end", 16'(m), 16'(run_en));
      cyc(30);
      cmp("run later", 16'(m), 16'(run_en));
      cmp("held target", m ? frq[2] : tfreq, tfreq);
      if (m == 1)
        pulse(1);
      clear;
    end
    mode = MODE_CONTINUOUS;
    // resume the interrupted step, then at the stored frequency
    for (int p = 1; p < 3; p++) begin
      pol = 2'(p);
      run13;
      cyc(8);
      hold = 1'b1;
      pulse(1);
      e = el;
      f = rfreq;
      pulse(0);
      cmp("resumed step", 16'h3, 16'(idx));
      cmp("resumed time", 16'h1, 16'(el >= e && el <= e + 16'h2));
      cmp("resume target", p == 2 ? f : frq[2], tfreq);
      hold = 1'b0;
      exp_q.push_back(4'h1);
      drain;
      pulse(1);
      clear;
    end
    // power loss with and without retention
    pol = RESUME_STEP;
    for (int r = 0; r < 2; r++) begin
      ret = r[0];
      prof[2] = PROF_W'($urandom);
      frq[2] = FREQ_W'($urandom) | 16'h8000;
      run13;
      cmp("outage ramp set", 16'(prof[2][2:1]), 16'(rset));
      cyc(4);
      if (r == 0)
        exp_q.push_back(4'h0);
      pulse(3);
      cmp("run at outage", 16'h0, 16'(run_en));
      if (r == 0)
        exp_q.push_back(4'h1);
      pulse(0);
      drain;
      cmp("outage step", r ? 16'h3 : 16'h1, 16'(idx));
      pulse(1);
      clear;
    end
    // minute unit; a zero first step still runs one tenth
    mode = MODE_STOP_AFTER;
    unit = UNIT_MINUTE;
    dur = '0;
    exp_q.push_back(4'h1);
    pulse(0);
    wait_done(n);
    cmp("minute step", 16'h1, 16'(n > 220 && n < 250));
    exp_q.push_back(4'h0);
    pulse(2);
    drain;
    cmp("queue left", 16'h0, 16'(exp_q.size()));
    finish_test;
  end
endmodule : dss_sequencer_test
